// >>> sdcmd_pkg.sv
package sdcmd_pkg;

  // ----------------------------------------
  // Array geometry
  // ----------------------------------------
  localparam int ROW_W = 12;
  localparam int COL_W = 9;
  localparam int BANK_W = 2;
  localparam int NBANK = 4;
  localparam int DATA_W = 16;

  // ----------------------------------------
  // Address pin and mode register fields
  // ----------------------------------------
  localparam int AP_BIT = 10;
  localparam int MR_BL_LSB = 0;
  localparam int MR_BT_BIT = 3;
  localparam int MR_CL_LSB = 4;
  localparam int MR_WB_BIT = 9;
  localparam logic [2:0] CL_THREE = 3'h3;
  localparam logic [2:0] BL_FULL = 3'h7;
  localparam logic [ROW_W-1:0] MODE_RESET = 12'h030;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_MODE = 4'h8;
  localparam logic [3:0] REG_RCNT = 4'hC;
  localparam logic CTRL_RESET = 1'b1;

  // ----------------------------------------
  // Commands and power states
  // ----------------------------------------
  typedef enum logic [2:0] {
    CMD_MRS = 3'b000,
    CMD_REF = 3'b001,
    CMD_PRE = 3'b010,
    CMD_ACT = 3'b011,
    CMD_WR  = 3'b100,
    CMD_RD  = 3'b101,
    CMD_BST = 3'b110,
    CMD_NOP = 3'b111
  } sdcmd_cmd_t;

  typedef enum logic [1:0] {
    PW_RUN  = 2'b00,
    PW_DOWN = 2'b01,
    PW_SUSP = 2'b10,
    PW_SELF = 2'b11
  } sdcmd_pwr_t;

  // Burst wrap mask; reserved codes behave as a full row
  function automatic logic [COL_W-1:0] sdcmd_bl_mask(input logic [2:0] code);
    case (code)
      3'h0: sdcmd_bl_mask = 9'h000;
      3'h1: sdcmd_bl_mask = 9'h001;
      3'h2: sdcmd_bl_mask = 9'h003;
      3'h3: sdcmd_bl_mask = 9'h007;
      default: sdcmd_bl_mask = 9'h1FF;
    endcase
  endfunction : sdcmd_bl_mask

endpackage : sdcmd_pkg

// >>> sdcmd_burst.sv
`timescale 1ns/1ps
`default_nettype none
module sdcmd_burst
  import sdcmd_pkg::*;
#(
  parameter int CW = COL_W
)
(
  input wire logic [CW-1:0] start_col,
  input wire logic [CW-1:0] beat,
  input wire logic [2:0] bl_code,
  input wire logic interleave,
  output logic [CW-1:0] col,
  output logic last
);

  logic [CW-1:0] mask;
  logic [CW-1:0] sum;

  always_comb begin
    mask = sdcmd_bl_mask(bl_code);
    sum = start_col + beat;
    // Full row (code 7) wraps sequentially; interleave applies to every other code, reserved codes included
    if (interleave && bl_code != BL_FULL) begin
      col = start_col ^ beat; // RULE_10
    end else begin
      col = (start_col & ~mask) | (sum & mask); // RULE_10
    end
    // A full-row burst never ends by itself, only by a new command
    last = (bl_code <= 3'h3) && (beat == mask); // RULE_09
  end

endmodule : sdcmd_burst
`default_nettype wire

// >>> sdcmd_store.sv
`timescale 1ns/1ps
`default_nettype none
module sdcmd_store
  import sdcmd_pkg::*;
#(
  parameter int AW = BANK_W + ROW_W + COL_W,
  parameter int DW = DATA_W
)
(
  input wire logic mclk,
  input wire logic clk_en,
  input wire logic [DW/8-1:0] wr_be,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);

  // ----------------------------------------
  // One array per byte lane
  // ----------------------------------------
  // Separate lanes keep each array to a single driver
  genvar g;
  for (g = 0; g < DW/8; g = g + 1) begin : g_lane
    logic [7:0] lane [2**AW];
    assign rdata[g*8 +: 8] = lane[addr];
    always_ff @(posedge mclk) begin
      if (clk_en && wr_be[g]) begin
        lane[addr] <= wdata[g*8 +: 8]; // RULE_14
      end
    end
  end

endmodule : sdcmd_store
`default_nettype wire

// >>> sdcmd_top.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE_01: Row takes all twelve address pins; column takes the low nine.
// RULE_02: Two bank pins pick one of four banks for activate, read, write.
// RULE_03: Chip deselected means new commands ignored, running burst carries on.
// RULE_04: Row, column and write strobes at a rising edge define the command.
// RULE_05: Read byte mask high floats that byte two cycles later.
// RULE_06: Write byte mask high blocks that byte in the same cycle.
// RULE_07: Clock gate low enters power-down, suspend or self-refresh.
// RULE_08: All inputs are sampled on the rising clock edge only.
// RULE_09: Bursts of one, two, four, eight or full row within an open row.
// RULE_10: Internal counter makes every column after the first.
// RULE_11: A new read every cycle interrupts the running burst.
// RULE_12: Read data follows after a column latency of two or three.
// RULE_13: Mode register sets burst length, latency and burst order.
// RULE_14: Upper and lower data bytes are masked independently.
// RULE_15: Controller must give 4096 refreshes in every 64 ms.
// RULE_16: Auto refresh on command; self-refresh keeps contents unattended.
// RULE_17: Precharge on command or automatically after the access.
// RULE_18: A mode with burst reads but single-word writes.
// RULE_19: Controller waits 20 ns from activate to read or write.
// RULE_20: Controller waits 20 ns from precharge to activate.
// RULE_21: Controller keeps a row open 45 ns to 100000 ns.
// RULE_22: Controller spaces activates to different banks by 15 ns.
// RULE_23: Controller waits 15 ns after mode programming.
// RULE_24: Controller spaces activate or refresh commands by 65 ns.
// RULE_25: Strobe encoding follows the usual synchronous DRAM command table.
module sdcmd_top
  import sdcmd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [ROW_W-1:0] mux_addr,
  input wire logic [BANK_W-1:0] bank_sel,
  input wire logic upper_byte_mask,
  input wire logic lower_byte_mask,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic [1:0] data_oe,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  sdcmd_pwr_t pwr, next_pwr;
  logic [ROW_W-1:0] mode, next_mode;
  logic [15:0] rcnt, next_rcnt;
  logic [NBANK-1:0] bank_open, next_bank_open;
  logic [ROW_W-1:0] bank_row [NBANK];
  logic [ROW_W-1:0] next_bank_row [NBANK];
  logic bst_act, next_bst_act;
  logic bst_wr, next_bst_wr;
  logic bst_ap, next_bst_ap;
  logic [BANK_W-1:0] bst_bank, next_bst_bank;
  logic [COL_W-1:0] bst_start, next_bst_start;
  logic [COL_W-1:0] bst_beat, next_bst_beat;
  logic [DATA_W-1:0] pd0, next_pd0, pd1, next_pd1;
  logic pv0, next_pv0, pv1, next_pv1;
  logic [1:0] dqm_q, next_dqm;
  logic [DATA_W-1:0] next_dout;
  logic [1:0] next_oe;
  logic ctrl_gate, next_gate;
  logic next_wait;
  logic [31:0] next_rd;

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  sdcmd_cmd_t cmd, cmd_eff;
  logic run, cas3, single_wr, new_rw, kill, beat_go, beat_wr, b_ap, b_last, blast;
  logic [BANK_W-1:0] b_bank;
  logic [COL_W-1:0] b_start, b_beat, b_col;
  logic [1:0] st_be;
  logic [DATA_W-1:0] st_rdata;

  always_comb begin
    run = (pwr == PW_RUN) && cke; // RULE_07
    cmd = cs_n ? CMD_NOP : sdcmd_cmd_t'({ras_n, cas_n, we_n}); // RULE_04 RULE_25
    cmd_eff = (run && ctrl_gate) ? cmd : CMD_NOP; // RULE_03
    cas3 = (mode[MR_CL_LSB +: 3] == CL_THREE); // RULE_12
    single_wr = mode[MR_WB_BIT]; // RULE_18
    new_rw = (cmd_eff == CMD_RD) || (cmd_eff == CMD_WR); // RULE_11
    kill = (cmd_eff == CMD_BST) || (cmd_eff == CMD_PRE && (mux_addr[AP_BIT] || bank_sel == bst_bank));
    beat_go = new_rw || (run && bst_act && !kill);
    beat_wr = new_rw ? (cmd_eff == CMD_WR) : bst_wr;
    b_bank = new_rw ? bank_sel : bst_bank; // RULE_02
    b_start = new_rw ? mux_addr[COL_W-1:0] : bst_start; // RULE_01
    b_beat = new_rw ? '0 : bst_beat;
    b_ap = new_rw ? mux_addr[AP_BIT] : bst_ap;
    blast = b_last || (beat_wr && single_wr); // RULE_18
    st_be = {2{beat_go && beat_wr}} & ~{upper_byte_mask, lower_byte_mask}; // RULE_06 RULE_14
  end

  sdcmd_burst #(.CW(COL_W)) u_burst (
    .start_col(b_start),
    .beat(b_beat),
    .bl_code(mode[MR_BL_LSB +: 3]),
    .interleave(mode[MR_BT_BIT]),
    .col(b_col),
    .last(b_last)
  );

  sdcmd_store #(.AW(BANK_W + ROW_W + COL_W), .DW(DATA_W)) u_store (
    .mclk(mclk),
    .clk_en(clk_en),
    .wr_be(st_be),
    .addr({b_bank, bank_row[b_bank], b_col}),
    .wdata(data_in),
    .rdata(st_rdata)
  );

  // ----------------------------------------
  // Banks, mode, refresh and power
  // ----------------------------------------
  always_comb begin
    next_mode = mode;
    next_rcnt = rcnt;
    next_bank_open = bank_open;
    next_bank_row = bank_row;
    next_pwr = pwr;
    case (cmd_eff)
      CMD_ACT: begin
        next_bank_open[bank_sel] = 1'b1; // RULE_02
        next_bank_row[bank_sel] = mux_addr; // RULE_01
      end
      CMD_PRE: begin
        if (mux_addr[AP_BIT]) begin
          next_bank_open = '0; // RULE_17
        end else begin
          next_bank_open[bank_sel] = 1'b0; // RULE_17
        end
      end
      CMD_MRS: next_mode = mux_addr; // RULE_13
      CMD_REF: next_rcnt = rcnt + 16'h0001; // RULE_16
      default: next_mode = mode;
    endcase
    if (beat_go && blast && b_ap) begin
      next_bank_open[b_bank] = 1'b0; // RULE_17
    end
    case (pwr)
      PW_RUN: begin
        if (!cke) begin
          if (ctrl_gate && cmd == CMD_REF) begin
            next_pwr = PW_SELF; // RULE_16
          end else if (bst_act) begin
            next_pwr = PW_SUSP; // RULE_07
          end else begin
            next_pwr = PW_DOWN; // RULE_07
          end
        end
      end
      PW_DOWN, PW_SUSP, PW_SELF: begin
        if (cke) begin
          next_pwr = PW_RUN;
        end
      end
      default: next_pwr = PW_RUN;
    endcase
  end

  // Inputs are only ever looked at on the rising edge, here as in every other clocked block
  always_ff @(posedge mclk) begin // RULE_08
    if (!rst_n) begin
      mode <= MODE_RESET;
      rcnt <= '0;
      bank_open <= '0;
      bank_row <= '{default: '0};
      pwr <= PW_RUN;
    end else if (clk_en) begin
      mode <= next_mode;
      rcnt <= next_rcnt;
      bank_open <= next_bank_open;
      bank_row <= next_bank_row;
      pwr <= next_pwr;
    end
  end

  // ----------------------------------------
  // Burst sequencer
  // ----------------------------------------
  always_comb begin
    next_bst_act = bst_act;
    next_bst_wr = bst_wr;
    next_bst_ap = bst_ap;
    next_bst_bank = bst_bank;
    next_bst_start = bst_start;
    next_bst_beat = bst_beat;
    if (beat_go) begin
      next_bst_act = !blast; // RULE_09
      next_bst_wr = beat_wr;
      next_bst_ap = b_ap;
      next_bst_bank = b_bank;
      next_bst_start = b_start; // RULE_11
      next_bst_beat = b_beat + 1'b1; // RULE_10
    end else if (kill) begin
      next_bst_act = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bst_act <= 1'b0;
      bst_wr <= 1'b0;
      bst_ap <= 1'b0;
      bst_bank <= '0;
      bst_start <= '0;
      bst_beat <= '0;
    end else if (clk_en) begin
      bst_act <= next_bst_act;
      bst_wr <= next_bst_wr;
      bst_ap <= next_bst_ap;
      bst_bank <= next_bst_bank;
      bst_start <= next_bst_start;
      bst_beat <= next_bst_beat;
    end
  end

  // ----------------------------------------
  // Read data pipeline
  // ----------------------------------------
  // While suspended the whole pipe holds, so output data stand still too
  always_comb begin
    next_pd0 = pd0;
    next_pv0 = pv0;
    next_pd1 = pd1;
    next_pv1 = pv1;
    next_dqm = dqm_q;
    next_dout = data_out;
    next_oe = data_oe;
    if (run) begin
      next_pd0 = st_rdata;
      next_pv0 = beat_go && !beat_wr;
      next_pd1 = pd0;
      next_pv1 = pv0;
      next_dqm = {upper_byte_mask, lower_byte_mask};
      next_dout = cas3 ? pd1 : pd0; // RULE_12
      next_oe = {2{cas3 ? pv1 : pv0}} & ~dqm_q; // RULE_05 RULE_14
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pd0 <= '0;
      pd1 <= '0;
      pv0 <= 1'b0;
      pv1 <= 1'b0;
      dqm_q <= '0;
      data_out <= '0;
      data_oe <= '0;
    end else if (clk_en) begin
      pd0 <= next_pd0;
      pd1 <= next_pd1;
      pv0 <= next_pv0;
      pv1 <= next_pv1;
      dqm_q <= next_dqm;
      data_out <= next_dout;
      data_oe <= next_oe;
    end
  end

  // ----------------------------------------
  // Register slave
  // ----------------------------------------
  // Fixed one-cycle wait: every access completes on the second edge
  always_comb begin
    next_wait = !((avs_read || avs_write) && avs_waitrequest);
    next_gate = ctrl_gate;
    next_rd = avs_readdata;
    if (avs_write && !avs_waitrequest && avs_address == REG_CTRL) begin
      next_gate = avs_writedata[0];
    end
    if (avs_read && avs_waitrequest) begin
      case (avs_address)
        REG_CTRL: next_rd = {31'h00000000, ctrl_gate};
        REG_STAT: next_rd = {25'h0000000, bst_act, pwr, bank_open};
        REG_MODE: next_rd = {20'h00000, mode};
        REG_RCNT: next_rd = {16'h0000, rcnt};
        default: next_rd = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_gate <= CTRL_RESET;
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
    end else if (clk_en) begin
      ctrl_gate <= next_gate;
      avs_waitrequest <= next_wait;
      avs_readdata <= next_rd;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n || !clk_en);

  a_mode_load: assert property (cmd_eff == CMD_MRS |=> mode == $past(mux_addr)) // RULE_13
    else $error("mode register not loaded");
  a_deselect_hold: assert property (cs_n && !bst_act |=> bank_open == $past(bank_open)) // RULE_03
    else $error("deselected command changed banks");
  a_act_open: assert property (cmd_eff == CMD_ACT && !(beat_go && blast && b_ap)
      |=> bank_open[$past(bank_sel)] && bank_row[$past(bank_sel)] == $past(mux_addr)) // RULE_01
    else $error("activate did not open row");
  a_lat_two: assert property ((cmd_eff == CMD_RD && !cas3 && !upper_byte_mask && !lower_byte_mask)
      ##1 (run && !cas3) |=> data_oe == 2'b11) // RULE_12
    else $error("latency two data missing");
  a_lat_three: assert property ((cmd_eff == CMD_RD && cas3 && !upper_byte_mask && !lower_byte_mask)
      ##1 (run && !upper_byte_mask && !lower_byte_mask) ##1 (run && cas3) |=> data_oe == 2'b11) // RULE_12
    else $error("latency three data missing");
  a_rd_mask: assert property ((run && upper_byte_mask) ##1 run |=> !data_oe[1]) // RULE_05
    else $error("masked read byte driven");
  a_wr_mask: assert property (beat_go && beat_wr && lower_byte_mask |-> !st_be[0]) // RULE_06
    else $error("masked write byte stored");
  a_pwr_entry: assert property (pwr == PW_RUN && !cke |=> pwr != PW_RUN) // RULE_07
    else $error("clock gate low ignored");
  a_single_wr: assert property (cmd_eff == CMD_WR && single_wr |=> !bst_act) // RULE_18
    else $error("single write ran a burst");
  a_auto_pre: assert property (beat_go && blast && b_ap && cmd_eff != CMD_ACT
      |=> !bank_open[$past(b_bank)]) // RULE_17
    else $error("auto precharge left bank open");
  a_burst_step: assert property (run && bst_act && !new_rw && !kill && !blast
      |=> bst_act && bst_beat == $past(bst_beat) + 1'b1) // RULE_10
    else $error("burst counter did not step");
  a_rd_restart: assert property (cmd_eff == CMD_RD |=> bst_start == $past(mux_addr[COL_W-1:0])) // RULE_11
    else $error("new read did not restart burst");
  a_ref_count: assert property (cmd_eff == CMD_REF |=> rcnt == $past(rcnt) + 16'h0001) // RULE_16
    else $error("refresh not counted");
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");

  c_rd_burst: cover property (cmd_eff == CMD_RD ##1 bst_act ##1 bst_act);
  c_wr_burst: cover property (cmd_eff == CMD_WR ##1 bst_act);
  c_self_ref: cover property (pwr == PW_RUN ##1 pwr == PW_SELF);
  c_bus_read: cover property (avs_read && !avs_waitrequest);

endmodule : sdcmd_top
`default_nettype wire

// >>> sdcmd_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
module sdcmd_ctl_model
  import sdcmd_pkg::*;
(
  input wire logic mclk,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [ROW_W-1:0] mux_addr,
  output logic [BANK_W-1:0] bank_sel,
  output logic upper_byte_mask,
  output logic lower_byte_mask,
  output logic [DATA_W-1:0] data_in
);
  initial begin
    cke = 1'b1;
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    mux_addr = 12'h000;
    bank_sel = 2'h0;
    {upper_byte_mask, lower_byte_mask} = 2'h0;
    data_in = 16'h5A5A;
  end

  // --------------------------------
  // Command tasks, entered just after an edge
  // --------------------------------
  task automatic put(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
                     input logic [1:0] dm, input logic [15:0] d);
    {cs_n, ras_n, cas_n, we_n} <= c;
    bank_sel <= b;
    mux_addr <= a;
    {upper_byte_mask, lower_byte_mask} <= dm;
    data_in <= d;
    @(posedge mclk);
  endtask : put

  // Deselect; the data lines stop showing the last word
  task automatic quiet(input int n);
    {cs_n, ras_n, cas_n, we_n} <= 4'hF;
    data_in <= ~data_in;
    repeat (n) @(posedge mclk);
  endtask : quiet

  // Three idle cycles keep 80 ns between activates and before column access
  task automatic act(input logic [1:0] b, input logic [11:0] r);
    put({1'b0, CMD_ACT}, b, r, 2'h0, data_in);
    quiet(3);
  endtask : act

  task automatic pre(input logic [1:0] b, input logic [11:0] a);
    put({1'b0, CMD_PRE}, b, a, 2'h0, data_in);
    quiet(1);
  endtask : pre

  task automatic mrs(input logic [11:0] v);
    put({1'b0, CMD_MRS}, 2'h0, v, 2'h0, data_in);
    quiet(1);
  endtask : mrs

  // The whole run is far shorter than one refresh period
  task automatic refresh();
    put({1'b0, CMD_REF}, 2'h0, 12'h000, 2'h0, data_in);
    quiet(3);
  endtask : refresh

  task automatic nap(input logic [3:0] c);
    cke <= 1'b0;
    put(c, 2'h0, 12'h000, 2'h0, data_in);
    quiet(1);
  endtask : nap

  task automatic wake();
    cke <= 1'b1;
    quiet(2);
  endtask : wake
endmodule : sdcmd_ctl_model
`default_nettype wire

// >>> sdcmd_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module sdcmd_top_tb_top
  import sdcmd_pkg::*;
;
  logic mclk, rst_n, cke, cs_n, ras_n, cas_n, we_n, upper_byte_mask, lower_byte_mask;
  logic [ROW_W-1:0] mux_addr;
  logic [BANK_W-1:0] bank_sel;
  logic [DATA_W-1:0] data_in, data_out;
  logic [1:0] data_oe, mask_d1, mask_d2, eoe;
  logic [3:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, mon_on, il, sw;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic pv [16];
  logic [15:0] pd [16];
  logic [15:0] mem [4][512];
  logic [15:0] lm;
  int bad_count, comparisons, bl, cl;

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  sdcmd_top uut (.mclk(mclk), .rst_n(rst_n), .clk_en(1'b1), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .mux_addr(mux_addr), .bank_sel(bank_sel),
    .upper_byte_mask(upper_byte_mask), .lower_byte_mask(lower_byte_mask),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  sdcmd_ctl_model ctl (.mclk(mclk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .mux_addr(mux_addr), .bank_sel(bank_sel), .upper_byte_mask(upper_byte_mask),
    .lower_byte_mask(lower_byte_mask), .data_in(data_in));

  // --------------------------------
  // Checking and bus tasks
  // --------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      bad_count++;
      give_verdict();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask : bus

  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(q, e);
  endtask : rchk

  // --------------------------------
  // Memory side tasks and expectations
  // --------------------------------
  function automatic logic [8:0] bcol(input logic [8:0] c, input int k);
    logic [8:0] m;
    m = 9'(bl - 1);
    bcol = il ? (c ^ 9'(k)) : ((c & ~m) | ((c + 9'(k)) & m));
  endfunction : bcol

  task automatic mode(input logic [11:0] v);
    ctl.mrs(v);
    bl = 1 << v[2:0];
    il = v[3];
    cl = int'(v[6:4]);
    sw = v[9];
    rchk(REG_MODE, {20'h0, v});
  endtask : mode

  task automatic wr(input logic [1:0] b, input logic [8:0] c, input logic [15:0] d,
                    input logic [7:0] dm);
    logic [15:0] v;
    logic [8:0] x;
    for (int k = 0; k < bl; k++) begin
      v = d + 16'(k) * 16'h0101;
      x = bcol(c, k);
      ctl.put(k == 0 ? {1'b0, CMD_WR} : {1'b0, CMD_NOP}, b, {3'h0, c}, dm[2*k+:2], v);
      if (k == 0 || !sw) begin
        if (!dm[2*k+1]) mem[b][x][15:8] = v[15:8];
        if (!dm[2*k]) mem[b][x][7:0] = v[7:0];
      end
    end
    ctl.quiet(1);
  endtask : wr

  // Later slots of a running burst are dropped: a new read cuts it short
  task automatic rd(input logic [1:0] b, input logic [11:0] a, input logic [1:0] dm);
    ctl.put({1'b0, CMD_RD}, b, a, dm, data_in);
    for (int s = cl - 1; s < 16; s++) pv[s] = 1'b0;
    for (int k = 0; k < bl; k++) begin
      pv[k + cl - 1] = 1'b1;
      pd[k + cl - 1] = mem[b][bcol(a[8:0], k)];
    end
  endtask : rd

  task automatic nops(input int n, input logic [1:0] dm);
    repeat (n) ctl.put({1'b0, CMD_NOP}, 2'h0, 12'h000, dm, data_in);
  endtask : nops

  always @(posedge mclk) begin
    mask_d1 <= {upper_byte_mask, lower_byte_mask};
    mask_d2 <= mask_d1;
  end

  // Every cycle: output only where a read beat is due, masked bytes floated
  always @(negedge mclk) begin
    if (mon_on) begin
      eoe = pv[0] ? ~mask_d2 : 2'h0;
      lm = {{8{eoe[1]}}, {8{eoe[0]}}};
      check({14'h0, data_oe, data_out & lm}, {14'h0, eoe, pd[0] & lm});
      for (int s = 0; s < 15; s++) begin
        pv[s] = pv[s + 1];
        pd[s] = pd[s + 1];
      end
      pv[15] = 1'b0;
    end
  end

  // --------------------------------
  // Test sequence
  // --------------------------------
  initial begin
    rst_n = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    mon_on = 1'b0;
    bad_count = 0;
    comparisons = 0;
    foreach (pv[i]) pv[i] = 1'b0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    mon_on = 1'b1;
    rchk(REG_CTRL, 32'h1);
    rchk(REG_STAT, 32'h0);
    rchk(REG_MODE, 32'h30);
    rchk(REG_RCNT, 32'h0);
    rchk(4'h2, 32'h0);
    bus(1'b1, REG_MODE, 32'hFFF);
    rchk(REG_MODE, 32'h30);
    $display("test registers done");
    mode(12'h022);
    ctl.act(2'h2, 12'hABC);
    rchk(REG_STAT, 32'h4);
    wr(2'h2, 9'h004, 16'h1111, 8'h00);
    wr(2'h2, 9'h004, 16'hA0B0, 8'h18);
    rd(2'h2, 12'h005, 2'h0);
    nops(5, 2'h0);
    rd(2'h2, 12'h004, 2'h2);
    nops(1, 2'h1);
    nops(4, 2'h0);
    $display("test burst done");
    rd(2'h2, 12'h004, 2'h0);
    rd(2'h2, 12'h006, 2'h0);
    nops(5, 2'h0);
    rd(2'h2, 12'h004, 2'h0);
    ctl.put({1'b1, CMD_RD}, 2'h2, 12'h006, 2'h0, data_in);
    nops(5, 2'h0);
    bus(1'b1, REG_CTRL, 32'h0);
    ctl.put({1'b0, CMD_RD}, 2'h2, 12'h006, 2'h0, data_in);
    nops(5, 2'h0);
    bus(1'b1, REG_CTRL, 32'h1);
    // Burst stop right after the read leaves only the first beat
    rd(2'h2, 12'h004, 2'h0);
    ctl.put({1'b0, CMD_BST}, 2'h2, 12'h000, 2'h0, data_in);
    for (int s = cl - 1; s < 16; s++) pv[s] = 1'b0;
    nops(4, 2'h0);
    $display("test gating done");
    mode(12'h03A);
    rd(2'h2, 12'h005, 2'h0);
    nops(6, 2'h0);
    mode(12'h222);
    wr(2'h2, 9'h004, 16'h7E57, 8'h00);
    rd(2'h2, 12'h004, 2'h0);
    nops(5, 2'h0);
    $display("test modes done");
    ctl.act(2'h1, 12'h123);
    rchk(REG_STAT, 32'h6);
    ctl.pre(2'h1, 12'h000);
    rchk(REG_STAT, 32'h4);
    rd(2'h2, 12'h404, 2'h0);
    nops(5, 2'h0);
    rchk(REG_STAT, 32'h0);
    ctl.act(2'h0, 12'h321);
    ctl.act(2'h3, 12'h321);
    rchk(REG_STAT, 32'h9);
    ctl.pre(2'h0, 12'h400);
    rchk(REG_STAT, 32'h0);
    $display("test precharge done");
    ctl.refresh();
    ctl.refresh();
    rchk(REG_RCNT, 32'h2);
    ctl.nap({1'b0, CMD_NOP});
    rchk(REG_STAT, 32'h10);
    ctl.wake();
    rchk(REG_STAT, 32'h0);
    ctl.nap({1'b0, CMD_REF});
    rchk(REG_STAT, 32'h30);
    ctl.wake();
    rchk(REG_STAT, 32'h0);
    $display("test power done");
    give_verdict();
  end
endmodule : sdcmd_top_tb_top
`default_nettype wire
